// file: core/fsps_arm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsps_cfg.svh"

module fsps_arm_timer #(
    parameter int W = 3
) (
    input  wire logic         clk_sys, // system clock
    input  wire logic         rst,     // sync reset, active high
    input  wire logic         start,   // control write armed a command
    input  wire logic         cancel,  // command consumed or dropped
    output logic      [W-1:0] rem_q    // cycles left in the window
);
    localparam logic [W-1:0] ARM_LEN = W'(`FSPS_ARM_CYCLES);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rem_q <= '0;
        end else if (start) begin
            rem_q <= ARM_LEN;
        end else if (cancel) begin
            rem_q <= '0;
        end else if (rem_q != '0) begin
            rem_q <= rem_q - W'(1);
        end
    end
endmodule // fsps_arm_timer

`default_nettype wire

// file: core/fsps_cfg.svh
`ifndef FSPS_CFG_SVH
`define FSPS_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define FSPS_OFS_CONTROL   8'h00
`define FSPS_OFS_PTR_LOW   8'h04
`define FSPS_OFS_PTR_HIGH  8'h08
`define FSPS_OFS_DATA_LOW  8'h0C
`define FSPS_OFS_DATA_HIGH 8'h10
`define FSPS_OFS_RESULT    8'h14

////////////////////////////////////////////////////////////////////////////////
// control field positions
`define FSPS_BIT_IRQ_EN    7
`define FSPS_BIT_RWW_BUSY  6
`define FSPS_BIT_RWW_REEN  4
`define FSPS_BIT_LOCK_SET  3
`define FSPS_BIT_PAGE_WR   2
`define FSPS_BIT_PAGE_ERS  1
`define FSPS_BIT_STORE_EN  0

// accepted lower-five-bit command patterns
`define FSPS_CMD_RWW_REEN  5'h11
`define FSPS_CMD_LOCK_SET  5'h09
`define FSPS_CMD_PAGE_WR   5'h05
`define FSPS_CMD_PAGE_ERS  5'h03
`define FSPS_CMD_LOAD      5'h01

////////////////////////////////////////////////////////////////////////////////
// reset values
`define FSPS_RST_CONTROL   8'h00
`define FSPS_RST_LOCK      8'hFF
`define FSPS_ERASED_WORD   16'hFFFF

////////////////////////////////////////////////////////////////////////////////
// timing
`define FSPS_CLK_NS        10
`define FSPS_ARM_CYCLES    4
`define FSPS_LOAD_CYCLES   3
`define FSPS_PROG_TIME_NS  3700000

`endif

// file: core/fsps_page_buffer.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsps_cfg.svh"

module fsps_page_buffer #(
    parameter int IDX_W = 7
) (
    input  wire logic             clk_sys, // system clock
    input  wire logic             rst,     // sync reset, active high
    input  wire logic             clear,   // drop all loaded words
    input  wire logic             we,      // store one word
    input  wire logic [IDX_W-1:0] widx,    // word slot
    input  wire logic [15:0]      wdata,   // word to store
    input  wire logic [IDX_W-1:0] ridx,    // read slot
    output logic      [15:0]      rdata_q  // registered read word
);
    localparam int DEPTH = 1 << IDX_W;

    logic [15:0]      mem [DEPTH];
    logic [DEPTH-1:0] vld_q;

    // clearing only drops valid bits; empty slots read as erased flash
    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            vld_q <= '0;
        end
        if (we && !rst) begin
            vld_q[widx] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[widx] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= `FSPS_ERASED_WORD;
        end else begin
            rdata_q <= vld_q[ridx] ? mem[ridx] : `FSPS_ERASED_WORD;
        end
    end
endmodule // fsps_page_buffer

`default_nettype wire

// file: core/fsps_pkg.sv
package fsps_pkg;

    // gray codes along idle -> armed -> busy; busy -> idle flips both bits
    typedef enum logic [1:0] {
        FSPS_IDLE  = 2'b00,
        FSPS_ARMED = 2'b01,
        FSPS_BUSY  = 2'b11
    } fsps_state_t;

    typedef logic [4:0] fsps_cmd_t;

endpackage : fsps_pkg

// file: core/fsps_top.sv
// Behaviour
// (RQ1) armed lock set plus store within four cycles programs lock bits from data low
// (RQ2) lock set command clears on completion or after four idle cycles
// (RQ3) armed lock set plus load within three cycles returns lock or fuse bits
// (RQ4) armed page write plus store within four cycles writes buffer to pointer page
// (RQ5) page write command clears when write ends or window expires
// (RQ6) page write stalls cpu for fixed region; fixed region stays readable otherwise
// (RQ7) armed page erase plus store within four cycles erases pointer page
// (RQ8) page erase command clears when erase ends or window expires
// (RQ9) plain store enable stores data high:low into buffer slot by word index
// (RQ10) store enable clears after store or window; stays high during erase/write
// (RQ11) only five accepted lower-bit patterns take effect; others ignored
// (RQ12) pointer splits into word-in-page low bits and page high bits
// (RQ13) operation latches its page address at start
// (RQ14) load addresses bytewise; pointer lsb selects byte
// (RQ15) software erases with page in pointer, pattern 00011, store within four cycles
// (RQ16) software writes with page in pointer, pattern 00101, store within four cycles
// (RQ17) page erase stalls cpu for fixed region; fixed region readable otherwise
// (RQ18) buffer clears after page write, on read reenable write, and on reset
// (RQ19) software loads each buffer slot at most once between clears
// (RQ20) eeprom write during buffer loading discards loaded data
// (RQ21) with irq enable set, interrupt stands while store enable is zero
// (RQ22) busy flag and read block hold through erase/write until reenabled
// (RQ23) armed read reenable plus store clears busy flag, never while busy
// (RQ24) writing read reenable during loading discards the buffer
// (RQ25) busy flag sets at rewritable erase/write start, clears on page load
// (RQ26) four-cycle window counter cancels armed command when it expires
// (RQ27) erase/write sequencer completion clears commands, store enable and stall
`timescale 1ns/10ps
`default_nettype none
`include "fsps_cfg.svh"

module fsps_top
    import fsps_pkg::*;
#(
    parameter int WORD_LOG2  = 7,      // words per page, log2
    parameter int RWW_PAGES  = 224,    // pages below this are rewritable
    parameter int PROG_CYCLES = (`FSPS_PROG_TIME_NS + `FSPS_CLK_NS - 1) / `FSPS_CLK_NS
) (
    input  wire logic         clk_sys,         // system clock
    input  wire logic         rst,             // sync reset, active high
    // axi4-lite slave
    input  wire logic [7:0]   s_axi_awaddr,    // write address
    input  wire logic         s_axi_awvalid,   // write address valid
    output logic              s_axi_awready,   // write address ready
    input  wire logic [31:0]  s_axi_wdata,     // write data
    input  wire logic [3:0]   s_axi_wstrb,     // write strobes
    input  wire logic         s_axi_wvalid,    // write data valid
    output logic              s_axi_wready,    // write data ready
    output logic [1:0]        s_axi_bresp,     // write response
    output logic              s_axi_bvalid,    // write response valid
    input  wire logic         s_axi_bready,    // write response ready
    input  wire logic [7:0]   s_axi_araddr,    // read address
    input  wire logic         s_axi_arvalid,   // read address valid
    output logic              s_axi_arready,   // read address ready
    output logic [31:0]       s_axi_rdata,     // read data
    output logic [1:0]        s_axi_rresp,     // read response
    output logic              s_axi_rvalid,    // read data valid
    input  wire logic         s_axi_rready,    // read data ready
    // cpu side
    input  wire logic         store_progmem_instr, // store instruction pulse
    input  wire logic         load_progmem_instr,  // load instruction pulse
    input  wire logic [7:0]   fuse_low,        // fuse bits for readout
    input  wire logic         eeprom_write,    // eeprom write in progress
    output logic [7:0]        load_data,       // lock or fuse readout
    output logic              load_valid,      // readout pulse
    output logic              cpu_stall,       // halt cpu
    output logic              rww_read_block,  // rewritable region unreadable
    output logic              selfprog_irq,    // ready interrupt level
    // flash array side
    output logic              flash_erase,     // erase start pulse
    output logic              flash_write,     // write start pulse
    output logic              flash_busy,      // erase or write running
    output logic [14-WORD_LOG2:0] flash_page,  // latched page
    input  wire logic [WORD_LOG2-1:0] buf_rd_idx, // buffer read slot
    output logic [15:0]       buf_rd_data      // buffer read word
);
    import fsps_pkg::*;

    localparam int PG_W = 15 - WORD_LOG2;
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam logic [CNT_W-1:0] PROG_LEN = CNT_W'(PROG_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    fsps_state_t        st_q;
    fsps_cmd_t          cmd_q;
    logic               irq_en_q;
    logic               rww_busy_q;
    logic [15:0]        ptr_q;
    logic [7:0]         dlo_q;
    logic [7:0]         dhi_q;
    logic [7:0]         lock_q;
    logic [PG_W-1:0]    page_q;
    logic [CNT_W-1:0]   prog_cnt_q;
    logic               loading_q;
    logic [2:0]         rem_q;
    logic               awready_q;
    logic               arready_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire       wr_fire   = awready_q && s_axi_awvalid && s_axi_wvalid;
    wire       rd_fire   = arready_q && s_axi_arvalid;
    wire       wr_ctl    = wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `FSPS_OFS_CONTROL;
    wire       wr_plo    = wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `FSPS_OFS_PTR_LOW;
    wire       wr_phi    = wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `FSPS_OFS_PTR_HIGH;
    wire       wr_dlo    = wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `FSPS_OFS_DATA_LOW;
    wire       wr_dhi    = wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `FSPS_OFS_DATA_HIGH;
    wire       wr_map    = s_axi_awaddr <= `FSPS_OFS_RESULT && s_axi_awaddr[1:0] == 2'h0;
    wire       rd_map    = s_axi_araddr <= `FSPS_OFS_RESULT && s_axi_araddr[1:0] == 2'h0;
    wire [4:0] wcmd      = s_axi_wdata[4:0];
    wire       pat_ok    = wcmd == `FSPS_CMD_RWW_REEN || wcmd == `FSPS_CMD_LOCK_SET ||
                           wcmd == `FSPS_CMD_PAGE_WR || wcmd == `FSPS_CMD_PAGE_ERS ||
                           wcmd == `FSPS_CMD_LOAD;
    // a busy flash keeps store enable high, so no new command arms then
    wire       arm       = wr_ctl && pat_ok && st_q != FSPS_BUSY; // [RQ11]
    wire       reen_wr   = arm && wcmd[`FSPS_BIT_RWW_REEN];

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode against the armed command
    wire       armed     = st_q == FSPS_ARMED && rem_q != 3'h0; // [RQ26]
    wire       st_ev     = armed && store_progmem_instr;
    wire       ld_win    = st_q == FSPS_ARMED && rem_q > 3'(`FSPS_ARM_CYCLES - `FSPS_LOAD_CYCLES);
    wire       ld_ev     = ld_win && load_progmem_instr && cmd_q == `FSPS_CMD_LOCK_SET; // [RQ3]
    wire       do_lock   = st_ev && cmd_q == `FSPS_CMD_LOCK_SET;
    wire       do_prog   = st_ev && (cmd_q == `FSPS_CMD_PAGE_WR || cmd_q == `FSPS_CMD_PAGE_ERS);
    wire       do_reen   = st_ev && cmd_q == `FSPS_CMD_RWW_REEN;
    wire       do_load   = st_ev && cmd_q == `FSPS_CMD_LOAD;
    wire       expire    = st_q == FSPS_ARMED && rem_q <= 3'h1 && !st_ev && !ld_ev;
    wire       prog_done = st_q == FSPS_BUSY && prog_cnt_q == CNT_W'(1);
    // the pointer: word-in-page in the low bits, page in the high bits
    wire [PG_W-1:0]      ptr_page = ptr_q[15:WORD_LOG2+1]; // [RQ12]
    wire [WORD_LOG2-1:0] ptr_word = ptr_q[WORD_LOG2:1]; // [RQ12]
    wire       ptr_fixed = 32'(ptr_page) >= RWW_PAGES;
    wire       pg_fixed  = 32'(page_q) >= RWW_PAGES;
    wire [7:0] lock_mask = {2'b11, dlo_q[5:2], 2'b11};
    wire       buf_clr   = (prog_done && cmd_q == `FSPS_CMD_PAGE_WR) || reen_wr || // [RQ18] [RQ24]
                           (eeprom_write && loading_q); // [RQ20]

    ////////////////////////////////////////////////////////////////////////////
    fsps_arm_timer #(.W(3)) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (arm),
        .cancel  (st_ev || ld_ev || st_q != FSPS_ARMED),
        .rem_q   (rem_q)
    );

    fsps_page_buffer #(.IDX_W(WORD_LOG2)) u_buf (
        .clk_sys (clk_sys),
        .rst     (rst),                       // [RQ18]
        .clear   (buf_clr),
        .we      (do_load),                   // [RQ9]
        .widx    (ptr_word),
        .wdata   ({dhi_q, dlo_q}),
        .ridx    (buf_rd_idx),
        .rdata_q (buf_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q  <= FSPS_IDLE;
            cmd_q <= 5'h00;
        end else if (arm) begin
            st_q  <= FSPS_ARMED;
            cmd_q <= wcmd;
        end else if (do_prog) begin
            st_q  <= FSPS_BUSY; // [RQ4] [RQ7] [RQ10]
        end else if (st_ev || ld_ev || expire || prog_done) begin
            st_q  <= FSPS_IDLE; // [RQ2] [RQ5] [RQ8] [RQ10] [RQ27]
            cmd_q <= 5'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            page_q     <= '0;
            prog_cnt_q <= '0;
        end else if (do_prog) begin
            page_q     <= ptr_page; // [RQ13]
            prog_cnt_q <= PROG_LEN;
        end else if (st_q == FSPS_BUSY) begin
            prog_cnt_q <= prog_cnt_q - CNT_W'(1);
        end
    end

    // lock bits live here; programmed means zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_q <= `FSPS_RST_LOCK;
        end else if (do_lock) begin
            lock_q <= lock_q & lock_mask; // [RQ1]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rww_busy_q <= 1'b0;
        end else if (do_prog && !ptr_fixed) begin
            rww_busy_q <= 1'b1; // [RQ22] [RQ25]
        end else if (do_reen || do_load) begin
            rww_busy_q <= 1'b0; // [RQ23] [RQ25]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || (buf_clr && !do_load)) begin
            loading_q <= 1'b0;
        end else if (do_load) begin
            loading_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_en_q <= 1'b0;
            ptr_q    <= 16'h0000;
            dlo_q    <= 8'h00;
            dhi_q    <= 8'h00;
        end else begin
            if (wr_ctl) irq_en_q   <= s_axi_wdata[`FSPS_BIT_IRQ_EN];
            if (wr_plo) ptr_q[7:0] <= s_axi_wdata[7:0];
            if (wr_phi) ptr_q[15:8] <= s_axi_wdata[7:0];
            if (wr_dlo) dlo_q      <= s_axi_wdata[7:0];
            if (wr_dhi) dhi_q      <= s_axi_wdata[7:0];
        end
    end

    wire [7:0] ctl_rd = {irq_en_q, rww_busy_q, 1'b0, cmd_q};
    logic [7:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr)
            `FSPS_OFS_CONTROL:   rd_mux = ctl_rd;
            `FSPS_OFS_PTR_LOW:   rd_mux = ptr_q[7:0];
            `FSPS_OFS_PTR_HIGH:  rd_mux = ptr_q[15:8];
            `FSPS_OFS_DATA_LOW:  rd_mux = dlo_q;
            `FSPS_OFS_DATA_HIGH: rd_mux = dhi_q;
            `FSPS_OFS_RESULT:    rd_mux = load_data;
            default:             rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite: address and data are taken together, one transfer at a time
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awready_q    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arready_q    <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= 32'h00000000;
        end else begin
            arready_q <= s_axi_arvalid && !arready_q && !s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_map ? 2'b00 : 2'b10;
                s_axi_rdata  <= {24'h000000, rd_mux};
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = awready_q;
    assign s_axi_arready = arready_q;

    ////////////////////////////////////////////////////////////////////////////
    // cpu and flash outputs, all registered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_data  <= 8'h00;
            load_valid <= 1'b0;
        end else begin
            load_valid <= ld_ev;
            if (ld_ev) load_data <= ptr_q[0] ? lock_q : fuse_low; // [RQ3] [RQ14]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cpu_stall   <= 1'b0;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_busy  <= 1'b0;
        end else begin
            if (do_prog) cpu_stall <= ptr_fixed; // [RQ6] [RQ17]
            else if (prog_done) cpu_stall <= 1'b0; // [RQ27]
            flash_erase <= do_prog && cmd_q == `FSPS_CMD_PAGE_ERS; // [RQ7]
            flash_write <= do_prog && cmd_q == `FSPS_CMD_PAGE_WR; // [RQ4]
            flash_busy  <= do_prog || (st_q == FSPS_BUSY && !prog_done);
        end
    end

    // irq follows the next state so it reaches its level with store enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            selfprog_irq <= 1'b0;
        end else begin
            selfprog_irq <= (wr_ctl ? s_axi_wdata[`FSPS_BIT_IRQ_EN] : irq_en_q) &&
                            !(arm || do_prog || (st_q != FSPS_IDLE && !st_ev && !ld_ev &&
                              !expire && !prog_done)); // [RQ21]
        end
    end

    assign flash_page     = page_q;
    assign rww_read_block = rww_busy_q; // [RQ22]

    ////////////////////////////////////////////////////////////////////////////
    AST_LOCK_PROG: assert property (@(posedge clk_sys) disable iff (rst) // [RQ1]
        do_lock |=> lock_q == ($past(lock_q) & $past(lock_mask)))
        else $error("lock bits not programmed from data low");

    AST_WINDOW_EXPIRE: assert property (@(posedge clk_sys) disable iff (rst) // [RQ2]
        (arm ##1 (!store_progmem_instr && !load_progmem_instr && !wr_ctl) [*4]) |=> cmd_q == 5'h00)
        else $error("armed command survived its window");

    AST_LOAD_READ: assert property (@(posedge clk_sys) disable iff (rst) // [RQ3]
        ld_ev |=> load_valid && load_data == ($past(ptr_q[0]) ? $past(lock_q) : $past(fuse_low)))
        else $error("lock or fuse readout wrong");

    AST_STALL_FIXED: assert property (@(posedge clk_sys) disable iff (rst) // [RQ6]
        (st_q == FSPS_BUSY && !$rose(st_q == FSPS_BUSY)) |-> cpu_stall == pg_fixed)
        else $error("stall does not match target region");

    AST_BAD_PATTERN: assert property (@(posedge clk_sys) disable iff (rst) // [RQ11]
        (wr_ctl && !pat_ok && st_q == FSPS_IDLE) |=> st_q == FSPS_IDLE && cmd_q == 5'h00)
        else $error("illegal command pattern took effect");

    AST_BUSY_KEEPS_EN: assert property (@(posedge clk_sys) disable iff (rst) // [RQ10]
        st_q == FSPS_BUSY |-> cmd_q[`FSPS_BIT_STORE_EN] && flash_busy)
        else $error("store enable dropped while flash busy");

    AST_PAGE_LATCH: assert property (@(posedge clk_sys) disable iff (rst) // [RQ13]
        (st_q == FSPS_BUSY && $past(st_q) == FSPS_BUSY) |-> $stable(page_q))
        else $error("page address moved during operation");

    AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (rst) // [RQ21]
        ##1 selfprog_irq == (irq_en_q && !cmd_q[`FSPS_BIT_STORE_EN]))
        else $error("interrupt level disagrees with store enable");

    AST_RWW_BUSY: assert property (@(posedge clk_sys) disable iff (rst) // [RQ25]
        (do_prog && !ptr_fixed) |=> rww_busy_q throughout (st_q == FSPS_BUSY) [*2])
        else $error("busy flag not held during rewritable operation");
endmodule // fsps_top

`default_nettype wire

// file: sim/fsps_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsps_cpu_model (
    input  wire logic       clk_sys,             // system clock
    input  wire logic       rst,                 // sync reset
    input  wire logic       kick,                // issue one instruction
    input  wire logic       ld,                  // 1 load, 0 store
    input  wire logic [1:0] dly,                 // extra cycles before issue
    output logic            store_progmem_instr, // store pulse
    output logic            load_progmem_instr   // load pulse
);
    logic       arm_q;
    logic       ld_q;
    logic       p_q;
    logic [1:0] cnt_q;
    // one pulse per instruction; an issue 2 or 3 cycles late lands outside the arming window
    always_ff @(posedge clk_sys) begin
        p_q <= 1'b0;
        if (rst) begin
            arm_q <= 1'b0;
        end else if (kick) begin
            ld_q  <= ld;
            cnt_q <= dly;
            arm_q <= (dly != 2'h0);
            p_q   <= (dly == 2'h0);
        end else if (arm_q) begin
            cnt_q <= cnt_q - 2'h1;
            arm_q <= (cnt_q != 2'h1);
            p_q   <= (cnt_q == 2'h1);
        end
    end
    assign store_progmem_instr = p_q & ~ld_q;
    assign load_progmem_instr  = p_q & ld_q;
endmodule // fsps_cpu_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_sys = 0, rst = 1, kick = 0, ld = 0, eeprom_write = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic store_progmem_instr, load_progmem_instr, load_valid, cpu_stall, rww_read_block;
    logic selfprog_irq, flash_erase, flash_write, flash_busy;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, fuse_low = 8'h5A, load_data, flash_page, pg, d;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'hb4d25dc6, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, dly = 0, rr;
    logic [6:0]  buf_rd_idx = 0;
    logic [15:0] buf_rd_data, wd;
    int n_fail = 0, samples_checked = 0, cyc = 0, k, seen;
    fsps_top #(.PROG_CYCLES(40)) i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .store_progmem_instr, .load_progmem_instr, .fuse_low,
        .eeprom_write, .load_data, .load_valid, .cpu_stall, .rww_read_block, .selfprog_irq,
        .flash_erase, .flash_write, .flash_busy, .flash_page, .buf_rd_idx, .buf_rd_data);
    fsps_cpu_model i_cpu (.clk_sys, .rst, .kick, .ld, .dly, .store_progmem_instr, .load_progmem_instr);
    always #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // call right after the control write
    task automatic go(input logic l, input logic [1:0] dl);
        kick <= 1'b1;
        ld   <= l;
        dly  <= dl;
        @(posedge clk_sys);
        kick <= 1'b0;
    endtask
    task automatic wt(input int w);
        seen = 0;
        for (k = 0; k < 60; k++) begin
            @(negedge clk_sys);
            seen = seen | (flash_write === 1'b1);
            if ((w == 0 && flash_erase) || (w == 1 && flash_write) || (w == 2 && load_valid) ||
                (w == 3 && !flash_busy) || (w == 4 && k == 9))
                break;
        end
    endtask
    task automatic close_out;
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        rst  <= 1'b0;
        seed = lfsr(lfsr(seed));
        axr(8'h00);
        chk(rd, 32'h00000000);
        axr(8'h18);
        chk(rr, 2'h2);
        axw(8'h00, 8'h80);
        wt(4);
        chk({rr, selfprog_irq}, 3'h1);
        axw(8'h00, 8'h07);
        axr(8'h00);
        chk(rd, 32'h00000000);
        wd = seed[31:16];
        axw(8'h04, {seed[6:0], 1'b1}); // each slot loaded once
        axw(8'h08, 8'h00);
        axw(8'h0C, wd[7:0]);
        axw(8'h10, wd[15:8]);
        axw(8'h00, 8'h01);
        go(1'b0, 2'h0);
        buf_rd_idx <= seed[6:0];
        wt(4);
        chk(buf_rd_data, wd);
        pg = {1'b0, seed[13:7]};
        axw(8'h04, 8'h00);
        axw(8'h08, pg);
        axw(8'h00, 8'h05);
        go(1'b0, 2'h1);
        wt(1);
        chk({flash_page, rww_read_block, cpu_stall, flash_write, flash_busy}, {pg, 4'b1011});
        axw(8'h08, ~pg);
        axr(8'h00);
        chk(rd, 32'h00000045);
        chk(flash_page, pg);
        wt(3);
        wt(4);
        chk(buf_rd_data, 16'hFFFF);
        axr(8'h00);
        chk(rd, 32'h00000040);
        axw(8'h00, 8'h11);
        go(1'b0, 2'h0);
        wt(4);
        chk(rww_read_block, 1'b0);
        buf_rd_idx <= 7'h00;
        axw(8'h00, 8'h01);
        go(1'b0, 2'h0);
        axw(8'h00, 8'h11);
        wt(4);
        chk(buf_rd_data, 16'hFFFF);
        axw(8'h00, 8'h01);
        go(1'b0, 2'h0);
        eeprom_write <= 1'b1;
        wt(4);
        chk(buf_rd_data, 16'hFFFF);
        pg = 8'hE0 | seed[20:16];
        axw(8'h08, pg);
        axw(8'h00, 8'h03);
        go(1'b0, 2'h0);
        wt(0);
        chk({flash_page, cpu_stall, rww_read_block, flash_erase}, {pg, 3'b101});
        wt(3);
        chk(cpu_stall, 1'b0);
        axr(8'h00);
        chk(rd, 32'h00000000);
        axw(8'h00, 8'h05);
        go(1'b0, 2'h2);
        wt(4);
        chk(seen, 0);
        d = {2'b11, seed[3:0], 2'b11};
        axw(8'h0C, d);
        axw(8'h00, 8'h09);
        go(1'b0, 2'h0);
        wt(4);
        axw(8'h04, 8'h01);
        axw(8'h00, 8'h09);
        go(1'b1, 2'h0);
        wt(2);
        chk({load_valid, load_data}, {1'b1, d});
        axw(8'h04, 8'h00);
        axw(8'h00, 8'h09);
        go(1'b1, 2'h0);
        wt(2);
        chk(load_data, fuse_low);
        axr(8'h00);
        chk(rd, 32'h00000000);
        close_out();
    end
endmodule // tb
`default_nettype wire
